//--- rtl/uvs_i2c_slave.v
// Two-wire slave interface of the ultraviolet sensor
`timescale 1ns/1ps
`include "uvs_defs.vh"
// Functional notes
// [RULE1] Write: start, address, ack, command, ack, stop
// [RULE2] Command writes accepted at address 38h
// [RULE3] Low byte at 38h, high at 39h
// [RULE4] Host never writes to address 39h
// [RULE5] One 8-bit command governs everything
// [RULE6] Host writes bits 7:6 as zero
// [RULE7] Host writes bit 1 as one
// [RULE8] Bit 5 enables alert above threshold
// [RULE9] Bit 4 picks 102 or 145 steps
// [RULE10] Bits 3:2 pick half, 1, 2, 4 T
// [RULE11] Bit 0 set enters shutdown
// [RULE12] Host reads high byte first
// [RULE13] Then host reads low byte
// [RULE14] Host clears alert, then writes 06h
// [RULE15] Host initialises within 150 ms
// [RULE16] Alert response read answers, releases alert
// [RULE17] Host without interrupt polls response address
// [RULE18] Alert output is open-drain, active low
// [RULE19] Threshold compared on the reading scale
// [RULE20] Read: start, address, ack, byte, ack, stop
// [RULE21] Default integration period is 1T
// [RULE22] Command and latest result are held
// [RULE23] Only the four own addresses are acknowledged
module uvl_i2c_slave #(
  parameter T_CYCLES = `UVL_BASE_CYCLES // Base period in cycles
) (
  input wire core_clk_i, // Core clock, 125 MHz
  input wire srst_i, // Synchronous reset, active high
  input wire scl_i, // Bus clock pin
  input wire sda_i, // Bus data pin level
  output reg sda_o, // Bus data drive value, always 0
  output reg sda_oe_n_o, // Low while pulling data low
  output reg alert_o, // Alert pin drive value, always 0
  output reg alert_oe_n_o, // Low while alert asserted
  input wire [15:0] sample_i, // Converter count from front end
  output reg shutdown_o, // Front end shutdown
  output reg [7:0] command_o // Current command value
);
  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  reg [1:0] scl_s_r; // scl two-flop sync
  reg [1:0] sda_s_r; // sda two-flop sync
  reg scl_d_r; // Delayed synced scl
  reg sda_d_r; // Delayed synced sda
  wire scl; // Synced scl
  wire sda; // Synced sda
  assign scl = scl_s_r[1];
  assign sda = sda_s_r[1];
  wire scl_rise = scl & ~scl_d_r; // Sample edge
  wire scl_fall = ~scl & scl_d_r; // Drive edge
  wire start_c = scl & scl_d_r & sda_d_r & ~sda; // Start or repeated start
  wire stop_c = scl & scl_d_r & ~sda_d_r & sda; // Stop

  // Synchronise pins before any logic
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  // ----------------------------------------
  // Measurement core
  // ----------------------------------------
  wire [15:0] result; // Latest completed reading
  wire done; // Capture pulse
  uvl_integrator #(
    .T_CYCLES(T_CYCLES)
  ) u_integ (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .period_sel_i(command_o[`UVL_CMD_PERIOD_HI:`UVL_CMD_PERIOD_LO]), // [RULE5]
    .shutdown_i(command_o[`UVL_CMD_SHUTDOWN]),
    .sample_i(sample_i),
    .result_o(result),
    .done_o(done)
  );

  // Address decode helper
  function addr_known;
    input [7:0] b;
    begin
      addr_known = (b[7:1] == `UVL_ADDR_LOW) || // [RULE23]
                   (b == {`UVL_ADDR_HIGH, 1'b1}) ||
                   (b == {`UVL_ADDR_ARA, 1'b1});
    end
  endfunction

  // ----------------------------------------
  // Transfer state machine
  // ----------------------------------------
  localparam ST_IDLE = 3'd0; // Waiting for start
  localparam ST_ADDR = 3'd1; // Shifting address byte
  localparam ST_AACK = 3'd2; // Address acknowledge slot
  localparam ST_WDAT = 3'd3; // Receiving command byte
  localparam ST_WACK = 3'd4; // Command acknowledge slot
  localparam ST_RDAT = 3'd5; // Sending data byte
  localparam ST_RACK = 3'd6; // Host acknowledge slot
  localparam ST_DONE = 3'd7; // Ignore until stop or start

  reg [2:0] st_r; // Current state
  reg [7:0] sh_r; // Shift register
  reg [3:0] bit_r; // Bit counter
  reg [7:0] addr_r; // Received address byte
  reg alert_r; // Alert pending
  reg [15:0] alert_level; // Selected alert level
  wire [7:0] ara_reply; // Own address returned to an alert response read
  assign ara_reply = {`UVL_ADDR_LOW, 1'b0};

  // Alert level in reading steps, same scale as result
  always @* begin
    alert_level = command_o[`UVL_CMD_LEVEL_SEL] ? `UVL_LEVEL_HIGH : `UVL_LEVEL_LOW; // [RULE9] [RULE19]
  end

  // Bus protocol, command register and alert logic
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      st_r <= ST_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      addr_r <= 8'h00;
      alert_r <= 1'b0;
      command_o <= `UVL_CMD_RESET; // [RULE21]
      shutdown_o <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      alert_o <= 1'b0;
      alert_oe_n_o <= 1'b1;
    end else begin
      shutdown_o <= command_o[`UVL_CMD_SHUTDOWN]; // [RULE11]
      alert_oe_n_o <= ~alert_r; // [RULE18]
      if (start_c) begin
        st_r <= ST_ADDR;
        bit_r <= 4'h0;
        sda_oe_n_o <= 1'b1;
      end else if (stop_c) begin
        st_r <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else begin
        case (st_r)
          ST_ADDR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              addr_r <= sh_r;
              bit_r <= 4'h0;
              if (addr_known(sh_r)) begin // [RULE2] [RULE3]
                sda_oe_n_o <= 1'b0;
                st_r <= ST_AACK;
              end else begin
                st_r <= ST_DONE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (addr_r[0]) begin
                // Load reply byte and drive its msb
                if (addr_r[7:1] == `UVL_ADDR_ARA) begin
                  sh_r <= ara_reply; // [RULE16]
                  alert_r <= 1'b0;
                  sda_oe_n_o <= ara_reply[7];
                end else if (addr_r[7:1] == `UVL_ADDR_HIGH) begin
                  sh_r <= result[15:8]; // [RULE3]
                  sda_oe_n_o <= result[15];
                end else begin
                  sh_r <= result[7:0];
                  sda_oe_n_o <= result[7];
                end
                st_r <= ST_RDAT; // [RULE20]
              end else begin
                sda_oe_n_o <= 1'b1;
                st_r <= ST_WDAT; // [RULE1]
              end
            end
          end
          ST_WDAT: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              command_o <= sh_r; // [RULE5] [RULE22]
              sda_oe_n_o <= 1'b0;
              st_r <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              sda_oe_n_o <= 1'b1;
              st_r <= ST_DONE;
            end
          end
          ST_RDAT: begin
            if (scl_rise) begin
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_r == 4'h8) begin
                sda_oe_n_o <= 1'b1;
                st_r <= ST_RACK;
              end else begin
                sh_r <= {sh_r[6:0], 1'b0};
                sda_oe_n_o <= sh_r[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              st_r <= ST_DONE;
            end
          end
          ST_IDLE, ST_DONE: begin
            sda_oe_n_o <= 1'b1;
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
      // Alert set on capture above the level; last, so a set beats a same-cycle release
      if (done && command_o[`UVL_CMD_ALERT_EN] && (result > alert_level)) begin // [RULE8]
        alert_r <= 1'b1;
      end else if (!command_o[`UVL_CMD_ALERT_EN]) begin
        alert_r <= 1'b0;
      end
    end
  end
endmodule

//--- rtl/uvs_defs.vh
// Constants of the ultraviolet sensor two-wire slave
`ifndef UVL_DEFS_VH
`define UVL_DEFS_VH
// ----------------------------------------
// Bus addresses (7-bit)
// ----------------------------------------
`define UVL_ADDR_LOW 7'h38
`define UVL_ADDR_HIGH 7'h39
`define UVL_ADDR_ARA 7'h0C
// ----------------------------------------
// Command fields and reset value
// ----------------------------------------
`define UVL_CMD_ALERT_EN 5
`define UVL_CMD_LEVEL_SEL 4
`define UVL_CMD_PERIOD_HI 3
`define UVL_CMD_PERIOD_LO 2
`define UVL_CMD_SHUTDOWN 0
`define UVL_CMD_RESET 8'h06
// ----------------------------------------
// Alert levels in steps
// ----------------------------------------
`define UVL_LEVEL_LOW 16'h0066
`define UVL_LEVEL_HIGH 16'h0091
// ----------------------------------------
// Integration timing (cycles of 125 MHz per base period, 125 ms)
// ----------------------------------------
`define UVL_CLK_HZ 125000000
`define UVL_BASE_MS 125
`define UVL_BASE_CYCLES ((`UVL_CLK_HZ / 1000) * `UVL_BASE_MS)
`endif

//--- rtl/uvs_integrator.v
// Integration period counter and result capture for the sensor core
`timescale 1ns/1ps
`include "uvs_defs.vh"
module uvl_integrator #(
  parameter T_CYCLES = `UVL_BASE_CYCLES // Base period T in clock cycles
) (
  input wire core_clk_i, // Core clock
  input wire srst_i, // Synchronous reset
  input wire [1:0] period_sel_i, // Integration period code
  input wire shutdown_i, // Low-power shutdown
  input wire [15:0] sample_i, // Converter count
  output reg [15:0] result_o, // Latest completed result
  output reg done_o // One-cycle pulse at capture
);
  // ----------------------------------------
  // Period counter
  // ----------------------------------------
  localparam [33:0] LIM_FULL = T_CYCLES; // One base period, widened to the counter
  localparam [33:0] LIM_HALF = LIM_FULL >> 1; // Half a base period
  localparam [33:0] LIM_DOUBLE = LIM_FULL << 1; // Two base periods
  localparam [33:0] LIM_QUAD = LIM_FULL << 2; // Four base periods
  reg [33:0] cnt_r; // Cycles elapsed
  wire [33:0] limit; // Period length in cycles
  assign limit = (period_sel_i == 2'b00) ? LIM_HALF : // [RULE10]
                 (period_sel_i == 2'b01) ? LIM_FULL :
                 (period_sel_i == 2'b10) ? LIM_DOUBLE : LIM_QUAD;

  // Count and capture at end of each period; counter held at zero in shutdown
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_r <= 34'h0;
      result_o <= 16'h0000;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (shutdown_i) begin // [RULE11]
        cnt_r <= 34'h0;
      end else if (cnt_r + 34'h1 >= limit) begin
        cnt_r <= 34'h0;
        result_o <= sample_i; // [RULE22]
        done_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 34'h1;
      end
    end
  end
endmodule

//--- tb/uvs_chk_assertions.sv
// Port assertions of the sensor two-wire slave
`timescale 1ns/1ps
module uvl_chk #(
  parameter T_CYCLES = 16 // Base period
) (
  input wire core_clk_i, // Clock
  input wire srst_i, // Reset
  input wire scl_i, // Bus clock
  input wire sda_i, // Data level
  input wire sda_o, // Data value
  input wire sda_oe_n_o, // Data pull
  input wire alert_o, // Alert value
  input wire alert_oe_n_o, // Alert pull
  input wire [15:0] sample_i, // Count
  input wire shutdown_o, // Shutdown
  input wire [7:0] command_o // Command
);
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  drive_zero_a: assert property (!sda_o && !alert_o) else $error("drive value not zero");
  reset_val_a: assert property (
    $fell(srst_i) |-> command_o == 8'h06 && sda_oe_n_o && alert_oe_n_o && !shutdown_o)
    else $error("bad value after reset");
  cmd_edge_a: assert property ($changed(command_o) |-> !scl_i) else $error("command moved with clock high");
  ack_edge_a: assert property ($changed(sda_oe_n_o) |-> !scl_i) else $error("data moved with clock high");
  ack_hold_a: assert property ($rose(scl_i) && !sda_oe_n_o |=> (!sda_oe_n_o) [*4]) else $error("pull dropped");
  alert_cause_a: assert property ($fell(alert_oe_n_o) |-> $past(command_o[5], 2))
    else $error("alert while disabled");
  alert_free_a: assert property (
    $rose(alert_oe_n_o) |-> !command_o[5] || !sda_oe_n_o || !$past(sda_oe_n_o))
    else $error("alert freed without cause");
  shut_copy_a: assert property ($stable(command_o) |-> shutdown_o == command_o[0]) else $error("shutdown wrong");
  cover property (!sda_oe_n_o);
  cover property ($fell(alert_oe_n_o));
  cover property ($rose(alert_oe_n_o));
  cover property (shutdown_o);
endmodule
bind uvl_i2c_slave uvl_chk #(.T_CYCLES(T_CYCLES)) i_chk (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o),
  .sample_i(sample_i), .shutdown_o(shutdown_o), .command_o(command_o));

//--- tb/uvs_host_bfm.sv
// Host bus master model on the clock and open-drain data line
`timescale 1ns/1ps
module uvl_host_bfm #(
  parameter int Q = 4 // Quarter bit in cycles
) (
  input wire logic core_clk_i, // Clock
  input wire logic sda_i, // Line level
  output logic scl_o = 1'b1, // Bus clock, idle high
  output logic sda_n_o = 1'b1, // Low pulls data
  output logic [8:0] res_o = 9'h000, // Reply {nack, byte}
  output logic vld_o = 1'b0 // Reply strobe
);
  // Wait some clock cycles
  task automatic w(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // One bit time: drive b (1 releases), sample mid-high
  task automatic bit_x(input logic b, output logic r);
    w(Q);
    sda_n_o <= b;
    w(Q);
    scl_o <= 1'b1;
    w(Q);
    r = sda_i;
    w(Q);
    scl_o <= 1'b0;
  endtask
  // One byte transfer from start to stop
  task automatic xfer(input logic [7:0] a, input logic [7:0] d);
    logic aa;
    logic ad;
    logic [7:0] rb;
    sda_n_o <= 1'b0; // Start
    w(Q);
    scl_o <= 1'b0;
    for (int i = 7; i >= 0; i--) bit_x(a[i], rb[i]);
    bit_x(1'b1, aa); // Address ack
    for (int i = 7; i >= 0; i--) bit_x(a[0] | d[i], rb[i]);
    bit_x(~a[0], ad); // Device acks a write, host acks a read
    w(Q);
    sda_n_o <= 1'b0;
    w(Q);
    scl_o <= 1'b1;
    w(Q);
    sda_n_o <= 1'b1; // Stop
    res_o <= {aa | (~a[0] & ad), rb};
    vld_o <= 1'b1;
    w(1);
    vld_o <= 1'b0;
    w(4 * Q);
  endtask
endmodule

//--- tb/uv_sensor_i2c_slave_tb.sv
// Self-checking bench of the sensor two-wire slave
`timescale 1ns/1ps
module uv_sensor_i2c_slave_tb;
  logic core_clk_i = 1'b0; // Clock
  logic srst_i = 1'b1; // Reset
  logic [15:0] sample_i = 16'h0000; // Converter count
  logic [15:0] s; // Random count
  logic [8:0] exp_q[$]; // Expected replies
  int mismatches = 0; // Mismatch count
  int num_checks = 0; // Check count
  int cyc = 0; // Cycle count
  wire scl, sda_n, sda_o, sda_oe_n_o, alert_o, alert_oe_n_o, shutdown_o, vld;
  wire [7:0] command_o; // Command
  wire [8:0] res; // Host reply
  wire sda = sda_n & sda_oe_n_o; // Pulled-up line
  always #4 core_clk_i = ~core_clk_i; // 125 MHz
  uvl_i2c_slave #(.T_CYCLES(16)) i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o), .sample_i(sample_i),
    .shutdown_o(shutdown_o), .command_o(command_o));
  uvl_host_bfm i_host (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_n_o(sda_n), .res_o(res), .vld_o(vld));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
    num_checks++;
    if (v !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bus transfer with its reply noted first
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
    exp_q.push_back(e);
    i_host.xfer(a, d);
  endtask
  // Hold a count for 100 cycles, more than one integration period at any setting
  task automatic settle(input logic [15:0] v);
    sample_i <= v;
    repeat (100) @(posedge core_clk_i);
  endtask
  // Timeout and reply compare
  always @(posedge core_clk_i) begin
    cyc++;
    if (vld) chk("reply", {7'h00, exp_q.size() ? exp_q.pop_front() : 9'h1EE}, {7'h00, res});
    if (cyc > 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h4A55F571));
    repeat (6) @(posedge core_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk("command", 16'h0006, {8'h00, command_o});
    chk("pins", 16'h0003, {14'h0000, alert_oe_n_o, sda_oe_n_o});
    xfer(8'h19, 8'h00, 9'h070);
    xfer(8'h70, 8'h06, 9'h006);
    s = $urandom;
    settle(s);
    xfer(8'h73, 8'h00, {1'b0, s[15:8]});
    xfer(8'h71, 8'h00, {1'b0, s[7:0]});
    for (int m = 0; m < 4; m++) begin
      xfer(8'h70, {4'h0, m[1:0], 2'b10}, {5'h00, m[1:0], 2'b10});
      chk("command", {12'h000, m[1:0], 2'b10}, {8'h00, command_o});
      s = $urandom;
      settle(s);
      xfer(8'h73, 8'h00, {1'b0, s[15:8]});
    end
    xfer(8'h72, 8'h3F, 9'h13F);
    xfer(8'h75, 8'h00, 9'h1FF);
    chk("command", 16'h000E, {8'h00, command_o});
    settle(16'h0000);
    for (int k = 0; k < 4; k++) begin
      xfer(8'h70, {3'b001, k[1], 4'h6}, {4'h1, k[1], 4'h6} & 9'h03F);
      settle((k[1] ? 16'h0091 : 16'h0066) + 16'(k[0]));
      settle(16'h0000);
      chk("alert", {15'h0000, ~k[0]}, {15'h0000, alert_oe_n_o});
      if (k[0]) begin
        xfer(8'h19, 8'h00, 9'h070);
        chk("alert", 16'h0001, {15'h0000, alert_oe_n_o});
      end
    end
    xfer(8'h70, 8'h07, 9'h007);
    settle(16'hFFFF);
    xfer(8'h73, 8'h00, 9'h000);
    chk("shutdown", 16'h0001, {15'h0000, shutdown_o});
    chk("alert", 16'h0001, {15'h0000, alert_oe_n_o});
    end_sim();
  end
endmodule
